// ===== design/fp_round_defs.svh
// register offsets, field positions and reset values of the rounding/exception block
`ifndef FP_ROUND_DEFS_SVH
`define FP_ROUND_DEFS_SVH

// register byte offsets on the APB side
`define OFS_SCALAR_CTRL 12'h000
`define OFS_SCALAR_STATUS 12'h004
`define OFS_PACKED_CSR 12'h008
`define OFS_OP_STATUS 12'h00C

// field positions
`define FLAG_LSB 0
`define SCALAR_MASK_LSB 0
`define SCALAR_MODE_LSB 10
`define PACKED_MASK_LSB 7
`define PACKED_MODE_LSB 13
`define OPST_TRAP_BIT 8
`define OPST_UNIT_BIT 9
`define OPST_WRITE_BIT 10

// widths
`define EXC_W 6
`define MODE_W 2
`define APB_ADDR_W 12

// reset values: every class masked, round to nearest even
`define MASK_RST 6'h3F
`define FLAGS_RST 6'h00
`define MODE_RST 2'h0

`endif

// ===== design/fp_round_pkg.sv
// types shared by the rounding and exception-control modules
package fp_round_pkg;

    typedef enum logic [1:0] {
        RND_NEAREST = 2'h0,
        RND_DOWN = 2'h1,
        RND_UP = 2'h2,
        RND_ZERO = 2'h3
    } round_mode_t;

    typedef enum logic [2:0] {
        OP_ARITH,
        OP_EXACT,
        OP_COMPARE,
        OP_NAN_RESULT,
        OP_TRUNC_CVT
    } op_kind_t;

    typedef enum logic {
        UNIT_SCALAR,
        UNIT_PACKED
    } unit_t;

    typedef enum logic [1:0] {
        RES_ROUNDED,
        RES_INDEFINITE,
        RES_INFINITY,
        RES_NONE
    } result_sel_t;

    // one fixed order for flags and masks alike, invalidOp in bit 0
    typedef struct packed {
        logic inexact;
        logic underflow;
        logic overflow;
        logic quotientFault;
        logic subnormalOperand;
        logic invalidOp;
    } exc_vec_t;

endpackage

// ===== design/round_if.sv
// carrier between the exception controller and its rounder
`timescale 1ns/10ps
`default_nettype none

interface round_if #(
    parameter int SIG_W = 64
);
    fp_round_pkg::round_mode_t mode;
    logic sign;
    logic [SIG_W-1:0] sig;
    logic roundBit;
    logic stickyBit;
    logic [SIG_W-1:0] rounded;
    logic carryOut;
    logic inexact;

    modport requester (
        output mode,
        output sign,
        output sig,
        output roundBit,
        output stickyBit,
        input rounded,
        input carryOut,
        input inexact
    );

    modport rounder (
        input mode,
        input sign,
        input sig,
        input roundBit,
        input stickyBit,
        output rounded,
        output carryOut,
        output inexact
    );
endinterface

`default_nettype wire

// ===== design/fp_rounder.sv
// picks between the two bracketing values according to the rounding mode
`timescale 1ns/10ps
`default_nettype none

module fp_rounder #(
    parameter int SIG_W = 64
) (
    round_if.rounder rnd
);
    logic increment;
    logic [SIG_W:0] sum;

    // sig is the value just below the exact result, sig+1 the one above
    always_comb begin
        case (rnd.mode)
            fp_round_pkg::RND_NEAREST: begin
                // ties go to the even neighbour
                increment = rnd.roundBit & (rnd.stickyBit | rnd.sig[0]); // [RULE_01]
            end
            fp_round_pkg::RND_DOWN: begin
                increment = rnd.sign & (rnd.roundBit | rnd.stickyBit); // [RULE_02]
            end
            fp_round_pkg::RND_UP: begin
                increment = ~rnd.sign & (rnd.roundBit | rnd.stickyBit); // [RULE_03]
            end
            fp_round_pkg::RND_ZERO: begin
                increment = 1'b0; // [RULE_04]
            end
            default: begin
                increment = 1'b0;
            end
        endcase
        sum = {1'b0, rnd.sig} + {{SIG_W{1'b0}}, increment}; // [RULE_06]
    end

    assign rnd.rounded = sum[SIG_W-1:0];
    assign rnd.carryOut = sum[SIG_W];
    assign rnd.inexact = rnd.roundBit | rnd.stickyBit; // [RULE_07]

endmodule

`default_nettype wire

// ===== design/fp_round_exc_ctrl.sv
// rounding and exception control for the scalar stack unit and the packed unit
//
// Function
// [RULE_01] mode 00: nearest value, ties to the even neighbour.
// [RULE_02] mode 01: round toward negative infinity.
// [RULE_03] mode 10: round toward positive infinity.
// [RULE_04] mode 11: truncate toward zero.
// [RULE_05] round to nearest even is the reset default.
// [RULE_06] choose between the two bracketing values, error under one ulp.
// [RULE_07] any rounding loss sets the inexact flag.
// [RULE_08] compares, exact and NaN results are untouched by the mode.
// [RULE_09] scalar unit mode sits in control word bits 10..11, scalar only.
// [RULE_10] packed unit mode sits in packed register bits 13..14, packed only.
// [RULE_11] truncating float-to-integer conversions always round toward zero.
// [RULE_12] six exception classes are detected.
// [RULE_13] invalid, divide-by-zero, denormal checked before arithmetic.
// [RULE_14] underflow, overflow, inexact checked after the result exists.
// [RULE_15] detected class sets its flag; masked gives predefined result.
// [RULE_16] unmasked class sets its flag and calls the software handler.
// [RULE_17] flags stay set until software clears them.
// [RULE_18] scalar flags status bits 0..5, masks control bits 0..5.
// [RULE_19] packed flags bits 0..5, masks bits 7..12 of one register.
// [RULE_20] the two flag/mask sets act only for their own unit.
// [RULE_21] masked responses let one operation raise several flags.
// [RULE_22] masked invalid writes the indefinite value to the destination.
// [RULE_23] unmasked invalid calls the handler, operands left unchanged.
// [RULE_24] flags and masks share one fixed bit order.
`timescale 1ns/10ps
`default_nettype none

`include "fp_round_defs.svh"

module fp_round_exc_ctrl #(
    parameter int SIG_W = 64
) (
    input wire logic clock,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // operation from the datapath
    input wire logic opValid,
    input wire fp_round_pkg::unit_t opUnit,
    input wire fp_round_pkg::op_kind_t opKind,
    input wire logic opSign,
    input wire logic [SIG_W-1:0] opSig,
    input wire logic opRoundBit,
    input wire logic opStickyBit,
    input wire logic opInvalid,
    input wire logic opQuotientFault,
    input wire logic opSubnormal,
    input wire logic opOverflow,
    input wire logic opUnderflow,
    // answer to the datapath
    output logic resValid,
    output logic [SIG_W-1:0] resSig,
    output logic resCarry,
    output fp_round_pkg::result_sel_t resSel,
    output logic resWrite,
    output fp_round_pkg::exc_vec_t resRaised,
    output logic resTrap
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        // software-visible control and flags
        fp_round_pkg::exc_vec_t scalarMask;
        fp_round_pkg::round_mode_t scalarMode;
        fp_round_pkg::exc_vec_t scalarFlags;
        fp_round_pkg::exc_vec_t packedMask;
        fp_round_pkg::round_mode_t packedMode;
        fp_round_pkg::exc_vec_t packedFlags;

        // last operation, read back as the op status word
        fp_round_pkg::exc_vec_t lastRaised;
        logic lastTrap;
        logic lastUnit;
        logic lastWrite;

        // registered bus answer
        logic pready;
        logic [31:0] prdata;
        logic pslverr;

        // registered datapath answer
        logic resValid;
        logic [SIG_W-1:0] resSig;
        logic resCarry;
        fp_round_pkg::result_sel_t resSel;
        logic resWrite;
        fp_round_pkg::exc_vec_t resRaised;
        logic resTrap;
    } state_t;

    state_t st_q;
    state_t st_d;

    // one rounder, shared by both units
    round_if #(.SIG_W(SIG_W)) rnd ();

    fp_rounder #(.SIG_W(SIG_W)) u_rounder (
        .rnd(rnd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // unit selection and rounding request

    fp_round_pkg::exc_vec_t unitMask;
    fp_round_pkg::round_mode_t unitMode;
    logic roundingApplies;

    always_comb begin
        // each unit sees only its own mode and masks
        if (opUnit == fp_round_pkg::UNIT_SCALAR) begin // [RULE_20]
            unitMask = st_q.scalarMask;
            unitMode = st_q.scalarMode; // [RULE_09]
        end else begin
            unitMask = st_q.packedMask;
            unitMode = st_q.packedMode; // [RULE_10]
        end

        // only rounded kinds pass lost bits on
        roundingApplies = (opKind == fp_round_pkg::OP_ARITH) ||
                          (opKind == fp_round_pkg::OP_TRUNC_CVT); // [RULE_08]
    end

    // conversions ignore both mode fields
    assign rnd.mode = (opKind == fp_round_pkg::OP_TRUNC_CVT) ?
                      fp_round_pkg::RND_ZERO : unitMode; // [RULE_11]
    assign rnd.sign = opSign;
    assign rnd.sig = opSig;
    // no rounding bits reach the rounder for exact, compare or NaN results
    assign rnd.roundBit = opRoundBit & roundingApplies; // [RULE_08]
    assign rnd.stickyBit = opStickyBit & roundingApplies; // [RULE_08]

    ////////////////////////////////////////////////////////////////////////////
    // exception classification

    fp_round_pkg::exc_vec_t preDet;
    fp_round_pkg::exc_vec_t postDet;
    fp_round_pkg::exc_vec_t raised;
    logic preTrap;
    logic postTrap;
    logic trap;
    logic doWrite;
    fp_round_pkg::result_sel_t sel;

    always_comb begin
        preDet = '0;
        postDet = '0;
        // operand checks, ahead of any arithmetic
        preDet.invalidOp = opInvalid; // [RULE_12] [RULE_13]
        preDet.quotientFault = opQuotientFault; // [RULE_13]
        preDet.subnormalOperand = opSubnormal; // [RULE_13]
        // result checks, on the rounded value
        postDet.overflow = opOverflow; // [RULE_14]
        postDet.underflow = opUnderflow; // [RULE_14]
        postDet.inexact = rnd.inexact; // [RULE_07] [RULE_14]

        preTrap = |(preDet & ~unitMask); // [RULE_16]
        postTrap = |(postDet & ~unitMask); // [RULE_16]
        raised = preDet;
        trap = 1'b0;
        doWrite = 1'b0;
        sel = fp_round_pkg::RES_NONE;

        // operand classes decide before result classes
        if (preTrap) begin
            // handler is called, destination and operands stay as they were
            trap = 1'b1; // [RULE_16] [RULE_23]
        end else if (preDet.invalidOp) begin
            doWrite = 1'b1;
            sel = fp_round_pkg::RES_INDEFINITE; // [RULE_15] [RULE_22]
        end else if (preDet.quotientFault) begin
            doWrite = 1'b1;
            sel = fp_round_pkg::RES_INFINITY; // [RULE_15]
        end else begin
            // a masked denormal goes on to the result checks
            raised = preDet | postDet; // [RULE_21]
            trap = postTrap; // [RULE_16]
            // the stack unit stores a biased result even when it traps
            doWrite = ~postTrap || (opUnit == fp_round_pkg::UNIT_SCALAR);
            sel = doWrite ? fp_round_pkg::RES_ROUNDED : fp_round_pkg::RES_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    logic setupPhase;
    logic accessDone;
    logic wrScalarCtrl;
    logic wrScalarStatus;
    logic wrPackedCsr;
    logic addrMapped;
    fp_round_pkg::exc_vec_t scalarClr;
    fp_round_pkg::exc_vec_t packedClr;
    logic [31:0] readWord;

    always_comb begin
        setupPhase = psel & ~penable & ~st_q.pready;
        accessDone = psel & penable & st_q.pready;
        addrMapped = (paddr == `OFS_SCALAR_CTRL) || (paddr == `OFS_SCALAR_STATUS) ||
                     (paddr == `OFS_PACKED_CSR) || (paddr == `OFS_OP_STATUS);
        wrScalarCtrl = accessDone & pwrite & (paddr == `OFS_SCALAR_CTRL);
        wrScalarStatus = accessDone & pwrite & (paddr == `OFS_SCALAR_STATUS);
        wrPackedCsr = accessDone & pwrite & (paddr == `OFS_PACKED_CSR);

        // flags clear by writing ones
        scalarClr = wrScalarStatus ? pwdata[`FLAG_LSB +: `EXC_W] : '0;
        packedClr = wrPackedCsr ? pwdata[`FLAG_LSB +: `EXC_W] : '0;

        // read word, taken in the setup cycle
        readWord = '0;
        case (paddr)
            `OFS_SCALAR_CTRL: begin
                readWord[`SCALAR_MASK_LSB +: `EXC_W] = st_q.scalarMask; // [RULE_18]
                readWord[`SCALAR_MODE_LSB +: `MODE_W] = st_q.scalarMode; // [RULE_09]
            end
            `OFS_SCALAR_STATUS: begin
                readWord[`FLAG_LSB +: `EXC_W] = st_q.scalarFlags; // [RULE_18]
            end
            `OFS_PACKED_CSR: begin
                readWord[`FLAG_LSB +: `EXC_W] = st_q.packedFlags; // [RULE_19]
                readWord[`PACKED_MASK_LSB +: `EXC_W] = st_q.packedMask; // [RULE_19]
                readWord[`PACKED_MODE_LSB +: `MODE_W] = st_q.packedMode; // [RULE_10]
            end
            `OFS_OP_STATUS: begin
                readWord[`FLAG_LSB +: `EXC_W] = st_q.lastRaised;
                readWord[`OPST_TRAP_BIT] = st_q.lastTrap;
                readWord[`OPST_UNIT_BIT] = st_q.lastUnit;
                readWord[`OPST_WRITE_BIT] = st_q.lastWrite;
            end
            default: begin
                readWord = '0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    fp_round_pkg::exc_vec_t scalarSet;
    fp_round_pkg::exc_vec_t packedSet;

    always_comb begin
        st_d = st_q;
        scalarSet = '0;
        packedSet = '0;
        if (opValid && (opUnit == fp_round_pkg::UNIT_SCALAR)) begin
            scalarSet = raised; // [RULE_20]
        end
        if (opValid && (opUnit == fp_round_pkg::UNIT_PACKED)) begin
            packedSet = raised; // [RULE_20]
        end

        // control fields written by software
        if (wrScalarCtrl) begin
            st_d.scalarMask = pwdata[`SCALAR_MASK_LSB +: `EXC_W]; // [RULE_18] [RULE_24]
            st_d.scalarMode = fp_round_pkg::round_mode_t'(
                pwdata[`SCALAR_MODE_LSB +: `MODE_W]); // [RULE_09]
        end

        // packed word also carries its w1c flags
        if (wrPackedCsr) begin
            st_d.packedMask = pwdata[`PACKED_MASK_LSB +: `EXC_W]; // [RULE_19] [RULE_24]
            st_d.packedMode = fp_round_pkg::round_mode_t'(
                pwdata[`PACKED_MODE_LSB +: `MODE_W]); // [RULE_10]
        end

        // sticky flags: a new event wins over a clear in the same cycle
        st_d.scalarFlags = (st_q.scalarFlags & ~scalarClr) | scalarSet; // [RULE_15] [RULE_17]
        st_d.packedFlags = (st_q.packedFlags & ~packedClr) | packedSet; // [RULE_15] [RULE_17]

        // answer to the datapath, one cycle after the request
        st_d.resValid = opValid;
        st_d.resRaised = opValid ? raised : '0;
        st_d.resTrap = opValid & trap; // [RULE_16]
        st_d.resWrite = opValid & doWrite;
        st_d.resSel = opValid ? sel : fp_round_pkg::RES_NONE;

        // significand and op status hold until the next op
        if (opValid) begin
            st_d.resSig = rnd.rounded; // [RULE_06]
            st_d.resCarry = rnd.carryOut;
            st_d.lastRaised = raised;
            st_d.lastTrap = trap;
            st_d.lastUnit = (opUnit == fp_round_pkg::UNIT_PACKED);
            st_d.lastWrite = doWrite;
        end

        // no wait state: ready and read data come up in the first access cycle
        st_d.pready = setupPhase;
        st_d.pslverr = setupPhase & ~addrMapped;
        st_d.prdata = (setupPhase & ~pwrite) ? readWord : '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_q <= '0;
            // all classes masked, nearest-even mode
            st_q.scalarMask <= `MASK_RST;
            st_q.packedMask <= `MASK_RST;
            st_q.scalarMode <= fp_round_pkg::round_mode_t'(`MODE_RST); // [RULE_05]
            st_q.packedMode <= fp_round_pkg::round_mode_t'(`MODE_RST); // [RULE_05]
            st_q.scalarFlags <= `FLAGS_RST;
            st_q.packedFlags <= `FLAGS_RST;
            st_q.resSel <= fp_round_pkg::RES_NONE;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // bus answer
    assign pready = st_q.pready;
    assign prdata = st_q.prdata;
    assign pslverr = st_q.pslverr;

    // datapath answer
    assign resValid = st_q.resValid;
    assign resSig = st_q.resSig;
    assign resCarry = st_q.resCarry;
    assign resSel = st_q.resSel;
    assign resWrite = st_q.resWrite;
    assign resRaised = st_q.resRaised;
    assign resTrap = st_q.resTrap;

endmodule

`default_nettype wire

// ===== verif/fp_round_chk.sv
// port assertions for the rounding and exception controller
`timescale 1ns/10ps
`default_nettype none
module fp_round_chk #(
    parameter int SIG_W = 64
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic opValid,
    input wire fp_round_pkg::op_kind_t opKind,
    input wire logic [SIG_W-1:0] opSig,
    input wire logic opRoundBit,
    input wire logic opStickyBit,
    input wire logic opInvalid,
    input wire logic opQuotientFault,
    input wire logic opSubnormal,
    input wire logic resValid,
    input wire logic [SIG_W-1:0] resSig,
    input wire logic resCarry,
    input wire fp_round_pkg::result_sel_t resSel,
    input wire logic resTrap,
    input wire fp_round_pkg::exc_vec_t resRaised
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic noPre;
    assign noPre = !opInvalid && !opQuotientFault && !opSubnormal;
    ////////////////////////////////////////////////////////////////
    chk_res_latency: assert property (opValid |=> resValid)
        else $error("no result one cycle after an operation");
    chk_res_idle: assert property (!opValid |=> !resValid && !resTrap && resRaised == 0)
        else $error("result without an operation");
    chk_apb_ready: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_cmp_exact: assert property (opValid && opKind == fp_round_pkg::OP_COMPARE
        |=> !resRaised.inexact)
        else $error("compare raised inexact");
    chk_exact_sig: assert property (opValid && opKind == fp_round_pkg::OP_EXACT && noPre
        |=> resSig == $past(opSig) && !resCarry && !resRaised.inexact)
        else $error("exact result altered");
    chk_trunc_sig: assert property (opValid && opKind == fp_round_pkg::OP_TRUNC_CVT && noPre
        |=> resSig == $past(opSig) && !resCarry)
        else $error("truncating conversion incremented");
    chk_inexact_set: assert property (opValid && opKind == fp_round_pkg::OP_ARITH && noPre
        && (opRoundBit || opStickyBit) |=> resRaised.inexact)
        else $error("lost bits without inexact");
    chk_pre_first: assert property (opValid && opInvalid |=> resRaised.invalidOp)
        else $error("invalid operand not raised");
    chk_trap_valid: assert property (resTrap |-> resValid)
        else $error("handler call outside a result");
    cover property (resTrap);
    cover property (pslverr);
    cover property (resSel == fp_round_pkg::RES_INDEFINITE);
endmodule

bind fp_round_exc_ctrl fp_round_chk #(.SIG_W(SIG_W)) u_fp_round_chk (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .opValid(opValid), .opKind(opKind), .opSig(opSig),
    .opRoundBit(opRoundBit), .opStickyBit(opStickyBit), .opInvalid(opInvalid),
    .opQuotientFault(opQuotientFault), .opSubnormal(opSubnormal), .resValid(resValid),
    .resSig(resSig), .resCarry(resCarry), .resSel(resSel), .resTrap(resTrap),
    .resRaised(resRaised)
);
`default_nettype wire

// ===== verif/fp_datapath_model.sv
// datapath stand-in launching one operation per call
`timescale 1ns/10ps
`default_nettype none
module fp_datapath_model #(
    parameter int SIG_W = 16
) (
    input wire logic clock,
    output logic opValid,
    output fp_round_pkg::unit_t opUnit,
    output fp_round_pkg::op_kind_t opKind,
    output logic opSign,
    output logic [SIG_W-1:0] opSig,
    output logic [6:0] opBits
);
    initial begin
        opValid = 0;
        opUnit = fp_round_pkg::UNIT_SCALAR;
        opKind = fp_round_pkg::OP_ARITH;
        opSign = 0;
        opSig = '0;
        opBits = '0;
    end
    task automatic issue(input logic u, input fp_round_pkg::op_kind_t k, input logic s,
        input logic [SIG_W-1:0] g, input logic [6:0] b);
        @(posedge clock);
        opValid <= 1;
        opUnit <= fp_round_pkg::unit_t'(u);
        opKind <= k;
        opSign <= s;
        opSig <= g;
        opBits <= b;
        @(posedge clock);
        opValid <= 0;
        // stale operands do not linger
        opSig <= ~g;
        opBits <= ~b;
    endtask
endmodule
`default_nettype wire

// ===== verif/fp_round_exc_ctrl_tb.sv
// self-checking bench of the rounding and exception controller
`timescale 1ns/10ps
`default_nettype none
module fp_round_exc_ctrl_tb;
    localparam int W = 16;
    logic clock = 0;
    logic sys_rst = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic pready, pslverr, opValid, opSign, resValid, resCarry, resWrite, resTrap;
    logic [31:0] prdata;
    fp_round_pkg::unit_t opUnit;
    fp_round_pkg::op_kind_t opKind;
    fp_round_pkg::result_sel_t resSel;
    fp_round_pkg::exc_vec_t resRaised;
    logic [W-1:0] opSig, resSig;
    logic [6:0] opBits;
    int errors = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'h0000_C695;
    logic [5:0] mask [2];
    logic [5:0] flags [2];
    logic [1:0] mode [2];
    logic [10:0] lastSt;
    initial forever #4 clock = ~clock;
    fp_round_exc_ctrl #(.SIG_W(W)) u_fp_round_exc_ctrl (
        .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .opValid(opValid), .opUnit(opUnit), .opKind(opKind), .opSign(opSign), .opSig(opSig),
        .opRoundBit(opBits[6]), .opStickyBit(opBits[5]), .opInvalid(opBits[4]),
        .opQuotientFault(opBits[3]), .opSubnormal(opBits[2]), .opOverflow(opBits[1]),
        .opUnderflow(opBits[0]), .resValid(resValid), .resSig(resSig), .resCarry(resCarry),
        .resSel(resSel), .resWrite(resWrite), .resRaised(resRaised), .resTrap(resTrap));
    fp_datapath_model #(.SIG_W(W)) u_fp_datapath_model (.clock(clock), .opValid(opValid),
        .opUnit(opUnit), .opKind(opKind), .opSign(opSign), .opSig(opSig), .opBits(opBits));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] ctrlWord(input int u);
        return u ? {17'h0, mode[1], mask[1], 7'h0} : {20'h0, mode[0], 4'h0, mask[0]};
    endfunction
    task automatic print_verdict();
        $display("counts: %0d compares, %0d mismatches", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk_res(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: result %h, expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic x);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        r = prdata;
        x = pslverr;
        psel <= 0;
        penable <= 0;
        if (pready !== 1'b1) begin
            errors++;
            print_verdict();
        end
    endtask
    task automatic chk_reg(input logic [11:0] a, input logic [31:0] e, input logic err);
        logic [31:0] r;
        logic x;
        apb(0, a, 32'h0, r, x);
        cmp_count++;
        if (r !== e || x !== err) begin
            errors++;
            $display("wrong value at %0t: reg %h read %h, expected %h", $time, a, r, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic x;
        apb(1, a, d, r, x);
    endtask
    task automatic check_all();
        chk_reg(12'h000, ctrlWord(0), 0);
        chk_reg(12'h004, {26'h0, flags[0]}, 0);
        chk_reg(12'h008, ctrlWord(1) | flags[1], 0);
        chk_reg(12'h00C, {21'h0, lastSt}, 0);
    endtask
    task automatic run_op();
        logic [31:0] a, b, c;
        logic u, inc, inx, rnds, trap, wrt;
        logic [5:0] pre, post, rs, mk;
        logic [1:0] m, sel;
        fp_round_pkg::op_kind_t k;
        logic [W-1:0] g;
        logic [6:0] bits;
        a = rnd();
        b = rnd();
        c = rnd();
        u = a[31];
        k = fp_round_pkg::op_kind_t'(a[30:28] % 5);
        g = (a[3:0] == 0) ? '1 : b[W-1:0];
        bits = {a[6:5], b[24:20] & c[24:20] & a[20:16]};
        rnds = k == fp_round_pkg::OP_ARITH || k == fp_round_pkg::OP_TRUNC_CVT;
        m = (k == fp_round_pkg::OP_TRUNC_CVT) ? 2'h3 : mode[u];
        case (m)
            2'h0: inc = bits[6] & (bits[5] | g[0]);
            2'h1: inc = a[7] & (bits[6] | bits[5]);
            2'h2: inc = ~a[7] & (bits[6] | bits[5]);
            default: inc = 0;
        endcase
        inc &= rnds;
        inx = rnds & (bits[6] | bits[5]);
        pre = {3'b0, bits[3], bits[2], bits[4]};
        post = {inx, bits[0], bits[1], 3'b0};
        mk = mask[u];
        trap = 0;
        wrt = 1;
        rs = pre;
        if (|(pre & ~mk)) begin
            trap = 1;
            wrt = 0;
            sel = fp_round_pkg::RES_NONE;
        end else if (pre[0]) begin
            sel = fp_round_pkg::RES_INDEFINITE;
        end else if (pre[2]) begin
            sel = fp_round_pkg::RES_INFINITY;
        end else begin
            rs = pre | post;
            trap = |(post & ~mk);
            wrt = !(trap && u);
            sel = wrt ? fp_round_pkg::RES_ROUNDED : fp_round_pkg::RES_NONE;
        end
        u_fp_datapath_model.issue(u, k, a[7], g, bits);
        #1;
        flags[u] |= rs;
        lastSt = {wrt, u, trap, 2'b0, rs};
        chk_res(resValid, 1);
        chk_res(resRaised, rs);
        chk_res(resTrap, trap);
        chk_res(resWrite, wrt);
        chk_res(resSel, sel);
        if (pre == 0) chk_res({resCarry, resSig}, {1'b0, g} + inc);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] a, b;
        mask = '{6'h3F, 6'h3F};
        flags = '{6'h00, 6'h00};
        mode = '{2'h0, 2'h0};
        lastSt = '0;
        repeat (4) @(posedge clock);
        sys_rst <= 0;
        check_all();
        chk_reg(12'h010, 32'h0, 1);
        wr(12'h00C, 32'hFFFF_FFFF);
        check_all();
        $display("test reset and map done");
        for (int t = 0; t < 40; t++) begin
            a = rnd();
            b = rnd();
            mask[0] = a[16] ? 6'h3F : a[5:0];
            mask[1] = a[16] ? 6'h3F : a[11:6];
            mode[0] = a[13:12];
            mode[1] = a[15:14];
            wr(12'h000, ctrlWord(0));
            wr(12'h008, ctrlWord(1));
            repeat (20) run_op();
            check_all();
            wr(12'h004, {26'h0, b[5:0]});
            flags[0] &= ~b[5:0];
            wr(12'h008, ctrlWord(1) | b[11:6]);
            flags[1] &= ~b[11:6];
            check_all();
        end
        $display("test random operations done");
        print_verdict();
    end
endmodule
`default_nettype wire
